//--- hdl/rvd_cfg.svh
// Offsets, field positions, reset values and timing figures of the reset sequencer
`ifndef RVD_CFG_SVH
`define RVD_CFG_SVH
`define RVD_ADDR_LVL 8'h00
`define RVD_ADDR_VDET 8'h04
`define RVD_ADDR_CAUSE 8'h08
`define RVD_ADDR_PORT 8'h0c
`define RVD_LVL_LOWSEL 0
`define RVD_LVL_MODESEL 7
`define RVD_LVL_RST 8'h00
`define RVD_CAUSE_LVD 0
`define RVD_CAUSE_RAM 1
`define RVD_CAUSE_ACC 2
`define RVD_CAUSE_WDT 4
`define RVD_CAUSE_ILL 7
`define RVD_PORT_IND 0
`define RVD_PORT_ALTCLK 1
`define RVD_OPT_MODE_HI 1
`define RVD_OPT_MODE_LO 0
`define RVD_OPT_LVL_MSB 7
`define RVD_OPT_LVL_LSB 4
`define RVD_LVL_MAX 4'ha
`define RVD_CLK_NS 4
`define RVD_T_FIRST_LVD_TYP_NS 672000
`define RVD_T_FIRST_LVD_MAX_NS 832000
`define RVD_T_FIRST_OFF_TYP_NS 399000
`define RVD_T_FIRST_OFF_MAX_NS 519000
`define RVD_T_LATER_LVD_TYP_NS 531000
`define RVD_T_LATER_LVD_MAX_NS 675000
`define RVD_T_LATER_OFF_TYP_NS 259000
`define RVD_T_LATER_OFF_MAX_NS 362000
`define RVD_T_STAB_TYP_NS 990000
`define RVD_T_STAB_MAX_NS 2300000
`define RVD_CYC(ns) (((ns) + `RVD_CLK_NS - 1) / `RVD_CLK_NS)
`define RVD_CNT_W 20
`endif

//--- hdl/rvd_pkg.sv
// Types shared by the reset sequencer modules
package rvd_pkg;
  typedef enum logic [3:0]
  {
    ST_HOLD = 4'b0001,
    ST_STAB = 4'b0010,
    ST_PROC = 4'b0100,
    ST_RUN  = 4'b1000
  } rvd_state_t;
  typedef enum logic [1:0]
  {
    MD_OFF    = 2'b00,
    MD_INT    = 2'b01,
    MD_INTRST = 2'b10,
    MD_RST    = 2'b11
  } rvd_mode_t;
endpackage : rvd_pkg

//--- hdl/rvd_release_timer.sv
// Down counter that times the stabilisation wait and the reset processing
`timescale 1ns/1ns
`default_nettype none
`include "rvd_cfg.svh"
module rvd_release_timer
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   load,
  input  wire logic [`RVD_CNT_W-1:0]  loadVal,
  output var  logic                   done
);
  logic [`RVD_CNT_W-1:0] cnt_ff;

  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_ff <= '1;
    else if (load)
      cnt_ff <= loadVal;
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - `RVD_CNT_W'(1);
  end

  always_comb
  begin
    done = (cnt_ff == '0);
  end
endmodule : rvd_release_timer
`default_nettype wire

//--- hdl/rvd_detector.sv
// Supply voltage detector: mode logic, interrupt and reset generation
`timescale 1ns/1ns
`default_nettype none
module rvd_detector
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire rvd_pkg::rvd_mode_t mode,
  input  wire logic              lowSel,
  input  wire logic              rstSel,
  input  wire logic              aboveHigh,
  input  wire logic              aboveLow,
  input  wire logic              porOk,
  output var  logic              lvdReset,
  output var  logic              irqPulse,
  output var  logic              levelFlag
);
  import rvd_pkg::*;
  logic armed_ff;
  logic prevHigh_ff;
  logic nxt_lvdReset;

  // Interrupt mode holds reset until the supply first reaches the level
  always_ff @(posedge clk)
  begin
    if (reset || !porOk)
      armed_ff <= 1'b0;
    else if (aboveHigh)
      armed_ff <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      prevHigh_ff <= 1'b0;
    else
      prevHigh_ff <= aboveHigh;
  end

  always_comb
  begin
    nxt_lvdReset = lvdReset;
    unique case (mode)
      MD_OFF:    nxt_lvdReset = 1'b0;
      MD_INT:    nxt_lvdReset = !(armed_ff || aboveHigh);
      MD_RST:    nxt_lvdReset = !aboveHigh;
      MD_INTRST:
      begin
        if (rstSel && lowSel && !aboveLow)
          nxt_lvdReset = 1'b1;
        else if (aboveHigh)
          nxt_lvdReset = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      lvdReset <= 1'b0;
    else
      lvdReset <= nxt_lvdReset;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irqPulse <= 1'b0;
    else
      unique case (mode)
        MD_INTRST: irqPulse <= prevHigh_ff && !aboveHigh && !rstSel;
        MD_INT:    irqPulse <= armed_ff && (prevHigh_ff != aboveHigh);
        MD_RST,
        MD_OFF:    irqPulse <= 1'b0;
      endcase
  end

  // Flag is high while the detector is not off and the supply is below the active level
  always_ff @(posedge clk)
  begin
    if (reset)
      levelFlag <= 1'b0;
    else
      levelFlag <= (mode != MD_OFF) && !((mode == MD_INTRST && lowSel) ? aboveLow : aboveHigh);
  end
endmodule : rvd_detector
`default_nettype wire

//--- hdl/rvd_sequencer.sv
// Reset and supply voltage detect sequencer, top level
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rvd_cfg.svh"
module rvd_sequencer
#(
  parameter int unsigned P_FIRST_LVD = `RVD_CYC(`RVD_T_FIRST_LVD_TYP_NS),
  parameter int unsigned P_FIRST_OFF = `RVD_CYC(`RVD_T_FIRST_OFF_TYP_NS),
  parameter int unsigned P_LATER_LVD = `RVD_CYC(`RVD_T_LATER_LVD_TYP_NS),
  parameter int unsigned P_LATER_OFF = `RVD_CYC(`RVD_T_LATER_OFF_TYP_NS),
  parameter int unsigned P_STAB      = `RVD_CYC(`RVD_T_STAB_TYP_NS)
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output var  logic [7:0] rdData,
  input  wire logic [7:0] optionByte,
  input  wire logic       porOk,
  input  wire logic       aboveHigh,
  input  wire logic       aboveLow,
  input  wire logic       extResetN,
  input  wire logic       wdtOverflow,
  input  wire logic       illegalInstr,
  input  wire logic       ramParityErr,
  input  wire logic       illegalAccess,
  output var  logic       sysReset,
  output var  logic       hocoSel,
  output var  logic       wdtReset,
  output var  logic       resetIndOut,
  output var  logic       resetIndOe,
  output var  logic       debugPullupEn,
  output var  logic       voltDetIrq,
  output var  logic [3:0] levelSel
);
  import rvd_pkg::*;

  rvd_state_t            state_ff;
  rvd_state_t            nxtState;
  logic                  firstPor_ff;
  logic                  hizCause_ff;
  logic                  nxt_hizCause;
  logic                  nxt_wdtCause;
  logic [7:0]            lvl_ff;
  logic [7:0]            cause_ff;
  logic [1:0]            port_ff;
  logic [7:0]            nxt_rdData;
  logic                  anySrc;
  logic                  lvdOn;
  logic                  tmrLoad;
  logic [`RVD_CNT_W-1:0] tmrVal;
  logic                  tmrDone;
  logic                  lvdReset;
  logic                  lvdIrq;
  logic                  levelFlag;
  logic [3:0]            optLevel;
  logic [`RVD_CNT_W-1:0] lenCnt_ff;
  rvd_mode_t             mode;

  // Processing time for the release in progress
  function automatic logic [`RVD_CNT_W-1:0] procTime(input logic first, input logic withLvd);
    if (first)
      procTime = withLvd ? `RVD_CNT_W'(P_FIRST_LVD) : `RVD_CNT_W'(P_FIRST_OFF);
    else
      procTime = withLvd ? `RVD_CNT_W'(P_LATER_LVD) : `RVD_CNT_W'(P_LATER_OFF);
  endfunction : procTime

  always_comb
  begin
    mode     = rvd_mode_t'({optionByte[`RVD_OPT_MODE_HI], optionByte[`RVD_OPT_MODE_LO]});
    lvdOn    = (mode != MD_OFF);
    optLevel = optionByte[`RVD_OPT_LVL_MSB:`RVD_OPT_LVL_LSB];
  end

  rvd_detector u_detector
  (
    .clk       (clk),
    .reset     (reset),
    .mode      (mode),
    .lowSel    (lvl_ff[`RVD_LVL_LOWSEL]),
    .rstSel    (lvl_ff[`RVD_LVL_MODESEL]),
    .aboveHigh (aboveHigh),
    .aboveLow  (aboveLow),
    .porOk     (porOk),
    .lvdReset  (lvdReset),
    .irqPulse  (lvdIrq),
    .levelFlag (levelFlag)
  );

  rvd_release_timer u_timer
  (
    .clk     (clk),
    .reset   (reset),
    .load    (tmrLoad),
    .loadVal (tmrVal),
    .done    (tmrDone)
  );

  // Sources of reset
  always_comb
  begin
    anySrc = !porOk || !extResetN || lvdReset
           || wdtOverflow || illegalInstr || ramParityErr || illegalAccess;
  end

  // Sequencing
  always_comb
  begin
    nxtState = state_ff;
    tmrLoad  = 1'b0;
    tmrVal   = procTime(firstPor_ff, lvdOn);
    if (anySrc)
    begin
      nxtState = ST_HOLD;
      tmrLoad  = 1'b1;
      if (firstPor_ff)
        tmrVal = `RVD_CNT_W'(P_STAB);
    end
    else
      unique case (state_ff)
        ST_HOLD:
        begin
          // Load on leaving HOLD so that logic reset also starts a full wait
          nxtState = firstPor_ff ? ST_STAB : ST_PROC;
          tmrLoad  = 1'b1;
          if (firstPor_ff)
            tmrVal = `RVD_CNT_W'(P_STAB);
        end
        ST_STAB:
        begin
          if (tmrDone)
          begin
            nxtState = ST_PROC;
            tmrLoad  = 1'b1;
          end
        end
        ST_PROC:
        begin
          if (tmrDone)
            nxtState = ST_RUN;
        end
        ST_RUN:  nxtState = ST_RUN;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_ff <= ST_HOLD;
    else
      state_ff <= nxtState;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      firstPor_ff <= 1'b1;
    else if (state_ff == ST_PROC && nxtState == ST_RUN)
      firstPor_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      sysReset <= 1'b1;
    else
      sysReset <= (nxtState != ST_RUN);
  end

  // Pin reset and power-on reset float the debug pin
  always_comb
  begin
    nxt_hizCause = !porOk || !extResetN || (hizCause_ff && nxtState != ST_RUN);
    nxt_wdtCause = wdtOverflow || (wdtReset && nxtState != ST_RUN);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hizCause_ff   <= 1'b1;
      debugPullupEn <= 1'b0;
    end
    else
    begin
      hizCause_ff   <= nxt_hizCause;
      debugPullupEn <= !nxt_hizCause;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      wdtReset <= 1'b0;
    else
      wdtReset <= nxt_wdtCause;
  end

  // Indicator pin and clock select follow the reset state
  always_ff @(posedge clk)
  begin
    if (reset)
      port_ff <= 2'h0;
    else if (nxtState != ST_RUN)
      port_ff <= 2'h0;
    else if (wrStb && addr == `RVD_ADDR_PORT)
      port_ff <= wrData[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resetIndOut <= 1'b0;
      resetIndOe  <= 1'b1;
      hocoSel     <= 1'b1;
    end
    else
    begin
      resetIndOut <= (nxtState == ST_RUN) && port_ff[`RVD_PORT_IND];
      resetIndOe  <= 1'b1;
      hocoSel     <= (nxtState != ST_RUN) || !port_ff[`RVD_PORT_ALTCLK];
    end
  end

  // Detection level register, interrupt sets both select bits
  always_ff @(posedge clk)
  begin
    if (reset)
      lvl_ff <= `RVD_LVL_RST;
    else
    begin
      if (wrStb && addr == `RVD_ADDR_LVL)
      begin
        lvl_ff <= 8'h00;
        lvl_ff[`RVD_LVL_LOWSEL]  <= wrData[`RVD_LVL_LOWSEL];
        lvl_ff[`RVD_LVL_MODESEL] <= wrData[`RVD_LVL_MODESEL];
      end
      if (lvdIrq)
      begin
        lvl_ff[`RVD_LVL_LOWSEL]  <= 1'b1;
        lvl_ff[`RVD_LVL_MODESEL] <= 1'b1;
      end
    end
  end

  // Reset cause register, cleared by read, a new cause wins
  always_ff @(posedge clk)
  begin
    if (reset)
      cause_ff <= 8'h00;
    else
    begin
      if (rdStb && addr == `RVD_ADDR_CAUSE)
        cause_ff <= 8'h00;
      if (lvdReset)
        cause_ff[`RVD_CAUSE_LVD] <= 1'b1;
      if (ramParityErr)
        cause_ff[`RVD_CAUSE_RAM] <= 1'b1;
      if (illegalAccess)
        cause_ff[`RVD_CAUSE_ACC] <= 1'b1;
      if (wdtOverflow)
        cause_ff[`RVD_CAUSE_WDT] <= 1'b1;
      if (illegalInstr)
        cause_ff[`RVD_CAUSE_ILL] <= 1'b1;
    end
  end

  always_comb
  begin
    nxt_rdData = 8'h00;
    if (rdStb)
      unique case (addr)
        `RVD_ADDR_LVL:   nxt_rdData = lvl_ff;
        `RVD_ADDR_VDET:  nxt_rdData = {7'h00, levelFlag};
        `RVD_ADDR_CAUSE: nxt_rdData = cause_ff;
        `RVD_ADDR_PORT:  nxt_rdData = {6'h00, port_ff};
        default:         nxt_rdData = 8'h00;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdData <= 8'h00;
    else
      rdData <= nxt_rdData;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      voltDetIrq <= 1'b0;
    else
      voltDetIrq <= lvdIrq;
  end

  // Threshold index to the comparator, clamped to the last level
  always_ff @(posedge clk)
  begin
    if (reset)
      levelSel <= 4'h0;
    else
      levelSel <= (optLevel > `RVD_LVL_MAX) ? `RVD_LVL_MAX : optLevel;
  end

  // Cycles spent in the current state, for the checks below
  always_ff @(posedge clk)
  begin
    if (reset || nxtState != state_ff)
      lenCnt_ff <= '0;
    else
      lenCnt_ff <= lenCnt_ff + `RVD_CNT_W'(1);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_src_hold:
    assert property (anySrc |=> sysReset && state_ff == ST_HOLD)
      else $error("reset not held while a source is active");
  a_event_reset:
    assert property ((wdtOverflow || illegalInstr || ramParityErr || illegalAccess) |=> ##1 sysReset)
      else $error("event did not cause reset");
  a_auto_release:
    assert property ((state_ff == ST_PROC && tmrDone && !anySrc) |=> !sysReset)
      else $error("reset not released after processing");
  a_clock_hoco:
    assert property ($fell(sysReset) |-> hocoSel)
      else $error("fast oscillator not selected at release");
  a_first_len:
    assert property ((state_ff == ST_PROC && tmrDone && firstPor_ff)
                     |-> lenCnt_ff == procTime(1'b1, lvdOn))
      else $error("first release time wrong");
  a_later_len:
    assert property ((state_ff == ST_PROC && tmrDone && !firstPor_ff)
                     |-> lenCnt_ff == procTime(1'b0, lvdOn))
      else $error("later release time wrong");
  a_stab_len:
    assert property ((state_ff == ST_STAB && tmrDone) |-> lenCnt_ff == `RVD_CNT_W'(P_STAB))
      else $error("stabilisation wait wrong");
  a_ind_low:
    assert property (sysReset |-> !resetIndOut && resetIndOe)
      else $error("indicator pin not low in reset");
  a_pin_hiz:
    assert property ((!extResetN || !porOk) |=> !debugPullupEn && sysReset)
      else $error("debug pin pulled in pin or power reset");
  a_pin_pull:
    assert property ((wdtOverflow && !nxt_hizCause) |=> debugPullupEn)
      else $error("debug pin not pulled in other reset");
  a_wdt_clear:
    assert property (wdtOverflow |=> wdtReset throughout (sysReset [*2]))
      else $error("watchdog not reset");
  a_lvl_auto:
    assert property (lvdIrq |=> lvl_ff[`RVD_LVL_LOWSEL] && lvl_ff[`RVD_LVL_MODESEL])
      else $error("select bits not set by interrupt");
  a_cause_set:
    assert property (lvdReset |=> cause_ff[`RVD_CAUSE_LVD] && sysReset)
      else $error("detector cause flag not set");
  a_flag_read:
    assert property ((rdStb && addr == `RVD_ADDR_VDET) |=> rdData[0] == $past(levelFlag))
      else $error("level flag read wrong");

  c_first_boot: cover property (state_ff == ST_STAB ##1 state_ff == ST_PROC);
  c_release: cover property ($fell(sysReset));
  c_wdt_reset: cover property (wdtReset ##1 !wdtReset);
  c_detect_irq: cover property (voltDetIrq);
endmodule : rvd_sequencer
`default_nettype wire

//--- tb/rvd_supervisor_model.sv
// External supervisor, supply comparators and externally reset device
`timescale 1ns/1ns
`default_nettype none
module rvd_supervisor_model
#(
  parameter int unsigned P_POR  = 1,
  parameter int unsigned P_OPER = 3,
  parameter int unsigned P_HOLD = 4
)
(
  input  wire logic       clk,
  input  wire logic [3:0] supply,
  input  wire logic       pushBtn,
  input  wire logic [3:0] levelSel,
  input  wire logic       resetIndOut,
  input  wire logic       resetIndOe,
  output wire logic       porOk,
  output wire logic       aboveHigh,
  output wire logic       aboveLow,
  output wire logic       extResetN,
  output wire logic       extDevRst
);
  logic [3:0] holdCnt_ff = 4'h0;
  logic       extRstN_ff = 1'b0;
  logic       pinLast_ff = 1'b0;
  logic       pinLvl;
  // Analog comparators
  assign porOk     = supply >= 4'(P_POR);
  assign aboveHigh = {1'b0, supply} >= {1'b0, levelSel} + 5'h02;
  assign aboveLow  = {1'b0, supply} >= {1'b0, levelSel} + 5'h01;
  // Pin held low until supply stays in range for P_HOLD + 1 cycles
  always_ff @(posedge clk)
  begin
    if (supply < 4'(P_OPER) || pushBtn)
    begin
      holdCnt_ff <= 4'h0;
      extRstN_ff <= 1'b0;
    end
    else
    begin
      if (holdCnt_ff < 4'(P_HOLD))
        holdCnt_ff <= holdCnt_ff + 4'h1;
      extRstN_ff <= (holdCnt_ff == 4'(P_HOLD));
    end
  end
  assign extResetN = extRstN_ff;
  // Undriven pin shows the inverse of its last level
  assign pinLvl = resetIndOe ? resetIndOut : ~pinLast_ff;
  always_ff @(posedge clk) pinLast_ff <= pinLvl;
  assign extDevRst = ~pinLvl;
endmodule : rvd_supervisor_model
`default_nettype wire

//--- tb/tb_rvd_sequencer.sv
// Self-checking testbench of the reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_rvd_sequencer;
  localparam int FL = 20, FO = 12, LL = 16, LO = 8, ST = 30;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic       wrStb = 1'b0;
  logic       rdStb = 1'b0;
  logic [7:0] optionByte = 8'h00;
  logic [3:0] supply = 4'hf;
  logic       pushBtn = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [7:0] rdData, rd;
  logic [3:0] levelSel;
  logic       porOk, aboveHigh, aboveLow, extResetN, sysReset, hocoSel, wdtReset;
  logic       resetIndOut, resetIndOe, debugPullupEn, voltDetIrq, extDevRst;
  logic [7:0] causeTab [4] = '{8'h10, 8'h80, 8'h02, 8'h04};
  int         fails = 0;
  int         nTests = 0;
  int         n;
  always #2 clk = ~clk;
  rvd_sequencer #(.P_FIRST_LVD(FL), .P_FIRST_OFF(FO), .P_LATER_LVD(LL), .P_LATER_OFF(LO), .P_STAB(ST)) dut_u
  (
    .clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .optionByte(optionByte), .porOk(porOk), .aboveHigh(aboveHigh), .aboveLow(aboveLow), .extResetN(extResetN),
    .wdtOverflow(ev[0]), .illegalInstr(ev[1]), .ramParityErr(ev[2]), .illegalAccess(ev[3]),
    .sysReset(sysReset), .hocoSel(hocoSel), .wdtReset(wdtReset), .resetIndOut(resetIndOut),
    .resetIndOe(resetIndOe), .debugPullupEn(debugPullupEn), .voltDetIrq(voltDetIrq), .levelSel(levelSel)
  );
  rvd_supervisor_model sup_u
  (
    .clk(clk), .supply(supply), .pushBtn(pushBtn), .levelSel(levelSel), .resetIndOut(resetIndOut),
    .resetIndOe(resetIndOe), .porOk(porOk), .aboveHigh(aboveHigh), .aboveLow(aboveLow),
    .extResetN(extResetN), .extDevRst(extDevRst)
  );
  task automatic conclude();
    if (fails == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
  endtask : wr
  task automatic rdReg(input logic [7:0] a);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    rd = rdData;
  endtask : rdReg
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 4'h0;
  endtask : pulse
  task automatic setSupply(input logic [3:0] s);
    @(posedge clk);
    supply <= s;
  endtask : setSupply
  task automatic waitRel(input int lo, input int hi);
    int k;
    k = 0;
    while (sysReset !== 1'b0)
    begin
      tick();
      k++;
      if (k > 2000)
      begin
        fails++;
        conclude();
      end
    end
    check("releaseTime", {7'h00, (k >= lo && k <= hi)}, 8'h01);
  endtask : waitRel
  task automatic irqCount();
    n = 0;
    repeat (10)
    begin
      tick();
      n += (voltDetIrq === 1'b1);
    end
  endtask : irqCount
  task automatic powerUp(input logic [7:0] opt, input int lo);
    @(posedge clk);
    reset      <= 1'b1;
    optionByte <= opt;
    supply     <= 4'hf;
    repeat (12) tick();
    check("inReset", {4'h0, resetIndOe, sysReset, resetIndOut, debugPullupEn}, 8'h0c);
    @(posedge clk);
    reset <= 1'b0;
    waitRel(lo, lo + 6);
    check("hoco", {7'h00, hocoSel}, 8'h01);
    check("level", {4'h0, levelSel}, {4'h0, (opt[7:4] > 4'ha) ? 4'ha : opt[7:4]});
    check("pullup", {7'h00, debugPullupEn}, 8'h01);
  endtask : powerUp
  initial
  begin
    powerUp(8'h00, ST + FO);
    rdReg(8'h10);
    check("unmapped", rd, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h0c, 8'h03);
      repeat (2) tick();
      check("indHigh", {7'h00, extDevRst}, 8'h00);
      pulse(i);
      #1;
      check("evRst", {5'h00, sysReset, wdtReset, debugPullupEn}, {5'h00, 1'b1, (i == 0), 1'b1});
      check("indLow", {7'h00, extDevRst}, 8'h01);
      waitRel(LO, LO + 6);
      check("indStay", {6'h00, extDevRst, hocoSel}, 8'h03);
      rdReg(8'h08);
      check("cause", rd, causeTab[i]);
      rdReg(8'h08);
      check("causeClr", rd, 8'h00);
    end
    pulse(0);
    repeat (5) tick();
    pulse(1);
    waitRel(LO, LO + 6);
    rdReg(8'h08);
    check("cause2", rd, 8'h90);
    @(posedge clk);
    pushBtn <= 1'b1;
    repeat (4) tick();
    check("pinRst", {6'h00, sysReset, debugPullupEn}, 8'h02);
    @(posedge clk);
    pushBtn <= 1'b0;
    waitRel(LO + 4, LO + 12);
    setSupply(4'h4);
    irqCount();
    check("offMode", {6'h00, (n == 0), sysReset}, 8'h02);
    powerUp(8'h53, ST + FL);
    setSupply(4'h6);
    repeat (4) tick();
    check("rstMode", {7'h00, sysReset}, 8'h01);
    rdReg(8'h04);
    check("flagLow", rd, 8'h01);
    setSupply(4'hf);
    waitRel(LL, LL + 6);
    rdReg(8'h04);
    check("flagHigh", rd, 8'h00);
    rdReg(8'h08);
    check("lvdCause", rd, 8'h01);
    powerUp(8'h52, ST + FL);
    setSupply(4'h6);
    irqCount();
    check("irqRstIrq", {6'h00, (n == 1), sysReset}, 8'h02);
    rdReg(8'h00);
    check("autoBits", rd, 8'h81);
    setSupply(4'h4);
    repeat (4) tick();
    check("irqRstRst", {7'h00, sysReset}, 8'h01);
    setSupply(4'hf);
    waitRel(LL, LL + 6);
    powerUp(8'hf1, ST + FL);
    for (int j = 0; j < 2; j++)
    begin
      setSupply(j == 0 ? 4'h6 : 4'hf);
      irqCount();
      check("irqMode", {6'h00, (n == 1), sysReset}, 8'h02);
    end
    conclude();
  end
endmodule : tb_rvd_sequencer
`default_nettype wire
